// *** design/ihz_pkg.sv ***
// Constants shared by the instruction decode and hazard block
package ihz_pkg;
	// ****************************************
	// Register byte offsets
	// ****************************************
	localparam logic [7:0] A_INSTR = 8'h00; // Issue word / last word
	localparam logic [7:0] A_OPA   = 8'h04; // First add operand
	localparam logic [7:0] A_OPB   = 8'h08; // Second add operand
	localparam logic [7:0] A_RES   = 8'h0C; // Destination value
	localparam logic [7:0] A_STAT  = 8'h10; // Sticky exception flags
	localparam logic [7:0] A_DEC   = 8'h14; // Decoded fields
	localparam logic [7:0] A_COPEN = 8'h18; // Implemented coprocessors
	localparam logic [7:0] A_EVT   = 8'h1C; // Hazard event start
	localparam logic [7:0] A_PEND  = 8'h20; // Hazard effects pending
	// ****************************************
	// Instruction fields and encodings
	// ****************************************
	localparam logic [5:0]  OP_SPECIAL = 6'h00; // Function-coded group
	localparam logic [5:0]  FN_ADD     = 6'h20; // Register add
	localparam logic [3:0]  OP_COPZ    = 4'h4;  // Upper bits of cop ops
	localparam logic [31:0] SUPERSCALAR_INHIBIT_NOOP_WORD = 32'h0000_0040; // Inhibit no-op
	// ****************************************
	// Status bits and reset values
	// ****************************************
	localparam int S_OVF = 0; // Integer overflow
	localparam int S_RSV = 1; // Reserved instruction
	localparam int S_CPU = 2; // Coprocessor unusable
	localparam int S_ADD = 3; // Last issue was an add (level)
	localparam logic [3:0] COPEN_RST = 4'h1; // Only system coprocessor
	// ****************************************
	// Hazard spacings, in instructions
	// ****************************************
	localparam int NEV = 11;
	localparam logic [2:0] SP_WATCH_FETCH = 3'h2;
	localparam logic [2:0] SP_TLBW_FETCH  = 3'h3;
	localparam logic [2:0] SP_XHI_TLB     = 3'h1;
	localparam logic [2:0] SP_XHI_FETCH   = 3'h3;
	localparam logic [2:0] SP_INDEX       = 3'h1;
	localparam logic [2:0] SP_CU          = 3'h1;
	localparam logic [2:0] SP_RETPC       = 3'h1;
	localparam logic [2:0] SP_IPSET       = 3'h3;
	localparam logic [2:0] SP_OTHER       = 3'h2;
	localparam logic [2:0] SP_ICACHE      = 3'h3;
	localparam logic [2:0] SP_COMPARE     = 3'h4;
	localparam logic [NEV*3-1:0] SPACING = {SP_COMPARE, SP_ICACHE,
		SP_OTHER, SP_IPSET, SP_RETPC, SP_CU, SP_INDEX, SP_XHI_FETCH,
		SP_XHI_TLB, SP_TLBW_FETCH, SP_WATCH_FETCH};
endpackage

// *** design/ihz_decode.sv ***
// Instruction decode front end with hazard spacing tracker
// Behaviour
// - Add: major zero, function 100000
// - Overflow keeps destination, raises exception
// - Other pairs behave fully sequential
// - Watch write to fetch: two between
// - Watch write seen by loads immediately
// - TLB write: fetch three, data immediate
// - Translation high: tlb one, fetch three
// - Translation low, probe results seen immediately
// - Index write needs one before use
// - Usable bits change needs one
// - Return pc write one before return
// - Pending interrupt set taken three later
// - Other system writes need two
// - Compare write: timer visible four more
// - Reserved opcode raises reserved exception
// - Missing coprocessor raises unusable exception
// - Map rows bits 31..29, columns 28..26
// - Inhibit no-op acts as no-op
//
// Added by the designer: the address map and the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module ihz_decode
	import ihz_pkg::*;
(
	// Clock and reset
	input  wire logic        pclk,
	input  wire logic        presetn,
	// APB slave
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output var  logic [31:0] prdata,
	output var  logic        pready,
	output var  logic        pslverr
);
	// ****************************************
	// Decode functions
	// ****************************************
	// Main map entries that fault as reserved
	function automatic logic rsv_fn(input logic [5:0] op);
		logic [2:0] r;
		logic [2:0] c;
		// Row is the upper half of the opcode, column the lower half
		r = op[5:3];
		c = op[2:0];
		rsv_fn = (r == 3'd3 && c != 3'd4) || (r == 3'd4 && c == 3'd7)
			|| (r == 3'd5 && (c == 3'd4 || c == 3'd5))
			|| (r == 3'd6 && (c == 3'd4 || c == 3'd7))
			|| (r == 3'd7 && (c == 3'd3 || c == 3'd4 || c == 3'd7));
	endfunction
	// Class code: 0 function group, 1 reg-imm, 2 jump, 3 link jump,
	// 4 branch, 5 immediate, 7 outside the first two rows
	function automatic logic [2:0] cls_fn(input logic [5:0] op);
		if (op[5:3] == 3'd1) begin
			cls_fn = 3'd5;
		end else if (op[5:3] != 3'd0) begin
			cls_fn = 3'd7;
		end else if (op[2]) begin
			cls_fn = 3'd4;
		end else begin
			cls_fn = {1'b0, op[1:0]};
		end
	endfunction
	// ****************************************
	// State
	// ****************************************
	logic [31:0] instr_reg;  // Last issued word
	logic [31:0] opa_reg;    // Operand a
	logic [31:0] opb_reg;    // Operand b
	logic [31:0] res_reg;    // Destination register model
	logic [3:0]  stat_reg;   // Sticky flags and add level
	logic [3:0]  copen_reg;  // Coprocessor present bits
	logic [31:0] prdata_reg; // Read data captured at setup
	logic        err_reg;    // Unmapped access flag
	// Hazard countdowns, one per tracked event
	logic [2:0]  cnt_reg [NEV]; // Instructions still to go
	logic [NEV-1:0] pend;    // Effect not yet guaranteed
	// ****************************************
	// Bus decode
	// ****************************************
	wire setup   = psel && !penable;
	wire wr      = psel && penable && pwrite;
	// Writing the instruction register issues one instruction
	wire issue   = wr && paddr == A_INSTR;
	wire wr_opa  = wr && paddr == A_OPA;
	wire wr_opb  = wr && paddr == A_OPB;
	wire wr_stat = wr && paddr == A_STAT;
	wire wr_cop  = wr && paddr == A_COPEN;
	wire wr_evt  = wr && paddr == A_EVT;
	// Aligned words up to the pending register are mapped
	wire mapped  = paddr[1:0] == 2'b00 && paddr <= A_PEND;
	// ****************************************
	// Instruction decode of the issued word
	// ****************************************
	wire [5:0]  op     = pwdata[31:26];
	wire [5:0]  fn     = pwdata[5:0];
	wire        is_add = op == OP_SPECIAL && fn == FN_ADD;
	// Both no-op forms leave everything but the word, the add level and the hazard counts untouched
	wire        is_nop = pwdata == 32'h0000_0000 || pwdata == SUPERSCALAR_INHIBIT_NOOP_WORD;
	// Coprocessor group fills the first four columns of row two
	wire        is_cop = op[5:2] == OP_COPZ;
	wire        cp_bad = is_cop && !copen_reg[op[1:0]];
	wire        rs_bad = rsv_fn(op) && !is_nop;
	// Plain 32-bit sum; the carry out is not needed for the flag
	wire [31:0] sum    = opa_reg + opb_reg;
	// Signed overflow: equal input signs, differing result sign
	wire        ovf    = opa_reg[31] == opb_reg[31] && sum[31] != opa_reg[31];
	// Decoded view: class, row, column and the three register fields
	wire [31:0] dec_w  = {8'h00, cls_fn(instr_reg[31:26]),
		instr_reg[31:29], instr_reg[28:26], instr_reg[25:21],
		instr_reg[20:16], instr_reg[15:11]};
	// ****************************************
	// Read mux
	// ****************************************
	logic [31:0] rd_mux;
	always_comb begin
		// Unmapped offsets read zero
		if (paddr == A_INSTR) begin
			rd_mux = instr_reg;
		end else if (paddr == A_OPA) begin
			rd_mux = opa_reg;
		end else if (paddr == A_OPB) begin
			rd_mux = opb_reg;
		end else if (paddr == A_RES) begin
			rd_mux = res_reg;
		end else if (paddr == A_STAT) begin
			rd_mux = {28'h0000000, stat_reg};
		end else if (paddr == A_DEC) begin
			rd_mux = dec_w;
		end else if (paddr == A_COPEN) begin
			rd_mux = {28'h0000000, copen_reg};
		end else if (paddr == A_PEND) begin
			rd_mux = {21'h000000, pend};
		end else begin
			rd_mux = 32'h0000_0000;
		end
	end
	// Outputs: registered data, constant ready, gated error
	assign prdata  = prdata_reg;
	assign pready  = 1'b1; // Zero wait states
	assign pslverr = psel && penable && err_reg;
	// ****************************************
	// Bus capture
	// ****************************************
	// Read data and error are settled in setup, stable in access
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata_reg <= 32'h0000_0000;
			err_reg    <= 1'b0;
		end else if (setup) begin
			prdata_reg <= rd_mux;
			err_reg    <= !mapped;
		end
	end
	// ****************************************
	// Operand, word and control registers
	// ****************************************
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			instr_reg <= 32'h0000_0000;
			opa_reg   <= 32'h0000_0000;
			opb_reg   <= 32'h0000_0000;
			copen_reg <= COPEN_RST;
		end else begin
			if (issue) instr_reg <= pwdata;
			if (wr_opa) opa_reg <= pwdata;
			if (wr_opb) opb_reg <= pwdata;
			// New usable bits apply at once, earlier than required
			if (wr_cop) copen_reg <= pwdata[3:0];
		end
	end
	// ****************************************
	// Destination register
	// ****************************************
	// Only a clean add writes; overflow keeps the old value
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			res_reg <= 32'h0000_0000;
		end else if (issue && is_add && !ovf) begin
			res_reg <= sum;
		end
	end
	// ****************************************
	// Exception flags
	// ****************************************
	// Write one clears; a new event in the same cycle wins
	logic [3:0] stat_next;
	always_comb begin
		stat_next = stat_reg;
		if (wr_stat) stat_next[2:0] = stat_reg[2:0] & ~pwdata[2:0];
		if (issue) begin
			stat_next[S_ADD] = is_add;
			if (is_add && ovf) stat_next[S_OVF] = 1'b1;
			if (rs_bad) stat_next[S_RSV] = 1'b1;
			if (cp_bad) stat_next[S_CPU] = 1'b1;
		end
	end
	// Flags register, loaded from its next value every cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) stat_reg <= 4'h0;
		else stat_reg <= stat_next;
	end
	// ****************************************
	// Hazard tracker
	// ****************************************
	// Each event loads its spacing and counts down one per issue.
	// Zero-spacing pairs have no counter: effects are immediate.
	// Limitation: every issue counts as intervening, even a related one
	genvar g;
	generate
		for (g = 0; g < NEV; g++) begin : g_haz
			assign pend[g] = cnt_reg[g] != 3'h0;
			// Per-event countdown; a load beats a same-cycle issue
			always_ff @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					cnt_reg[g] <= 3'h0;
				end else if (wr_evt && pwdata[g]) begin
					cnt_reg[g] <= SPACING[g*3 +: 3];
				end else if (issue && pend[g]) begin
					cnt_reg[g] <= cnt_reg[g] - 3'h1;
				end
			end
		end
	endgenerate
	// ****************************************
	// Checks
	// ****************************************
	// All checks share the bus clock and are off in reset
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	// Clean add lands in the destination one cycle later
	add_write_a: assert property (issue && is_add && !ovf |=> res_reg == $past(sum))
		else $error("add result not written");
	// Overflow must neither touch the destination nor go unflagged
	ovf_keep_a: assert property (issue && is_add && ovf
		|=> $stable(res_reg) && stat_reg[S_OVF])
		else $error("overflow changed destination");
	// Add level follows the two fixed fields of the issued word
	add_seen_a: assert property (issue |=> stat_reg[S_ADD] == (
		$past(pwdata[31:26]) == 6'h00 && $past(pwdata[5:0]) == 6'h20))
		else $error("add decode wrong");
	// Row three, column zero is reserved
	resv_exc_a: assert property (issue && pwdata[31:29] == 3'd3 && pwdata[28:26] == 3'd0
		|=> stat_reg[S_RSV])
		else $error("reserved opcode missed");
	// Row seven, column seven is reserved as well
	resv_top_a: assert property (issue && pwdata[31:26] == 6'h3F |=> stat_reg[S_RSV])
		else $error("top reserved opcode missed");
	// The first two rows never fault as reserved
	row_clean_a: assert property (issue && pwdata[31:30] == 2'b00 && !stat_reg[S_RSV]
		|=> !stat_reg[S_RSV])
		else $error("valid map entry faulted");
	// Missing coprocessor raises the unusable flag
	cop_unus_a: assert property (issue && is_cop && !copen_reg[op[1:0]] |=> stat_reg[S_CPU])
		else $error("unusable coprocessor missed");
	// A present coprocessor does not raise it
	cop_fine_a: assert property (issue && is_cop && copen_reg[op[1:0]] && !stat_reg[S_CPU]
		|=> !stat_reg[S_CPU])
		else $error("usable coprocessor flagged");
	// Inhibit no-op leaves results and flags alone
	nop_quiet_a: assert property (issue && pwdata == SUPERSCALAR_INHIBIT_NOOP_WORD
		|=> $stable(res_reg) && $stable(stat_reg[2:0]))
		else $error("inhibit no-op had an effect");
	// One issue after the watch write the fetch effect is still pending
	watch_two_a: assert property (issue && !wr_evt && cnt_reg[0] == 3'h2
		|=> pend[0] && cnt_reg[0] == 3'h1)
		else $error("watch spacing count wrong");
	watch_load_a: assert property (wr_evt && pwdata[0] |=> cnt_reg[0] == 3'h2)
		else $error("watch spacing wrong");
	// Page mapping change reaches fetches after three
	tlbw_load_a: assert property (wr_evt && pwdata[1] |=> cnt_reg[1] == 3'h3)
		else $error("page mapping spacing wrong");
	// Translation high to table operations needs one
	xhi_load_a: assert property (wr_evt && pwdata[2] |=> cnt_reg[2] == 3'h1)
		else $error("translation high spacing wrong");
	// Timer compare effect may lag by four
	cmp_four_a: assert property (wr_evt && pwdata[10] |=> cnt_reg[10] == 3'h4)
		else $error("compare spacing wrong");
	// Each issue takes exactly one off a running count
	cnt_step_a: assert property (issue && !wr_evt && pend[3]
		|=> cnt_reg[3] == $past(cnt_reg[3]) - 3'h1)
		else $error("hazard count step wrong");
	late_none_a: assert property (pend[1] && cnt_reg[1] == 3'h1 && issue && !wr_evt
		|=> !pend[1])
		else $error("effect visible too late");
	// Decoded column of a link jump
	jump_map_a: assert property (issue && pwdata[31:26] == 6'h03 |=> dec_w[17:15] == 3'd3)
		else $error("map row zero wrong");
	// Zero wait states and an error only for holes in the map
	ready_err_a: assert property (psel && penable |-> pready && pslverr == !mapped)
		else $error("bus answer wrong");
	// Main scenarios to be reached
	cv_ovf_c: cover property (issue && is_add && ovf);
	cv_rsv_c: cover property (issue && rs_bad);
	cv_cop_c: cover property (issue && cp_bad);
	cv_haz_c: cover property (pend[3] ##1 !pend[3]);
	cv_clr_c: cover property (wr_stat && stat_reg[S_RSV]);
endmodule
`default_nettype wire

// *** testbench/instruction_decode_and_hazards_test.sv ***
// Self-checking bench for the instruction decode and hazard block
`timescale 1ns/1ps
`default_nettype none
module instruction_decode_and_hazards_test;
	import ihz_pkg::*;
	// ****************************************
	// Bench signals
	// ****************************************
	logic        pclk;        // Bus clock
	logic        presetn;     // Async reset, active low
	logic        psel;        // Select
	logic        penable;     // Access phase
	logic        pwrite;      // Direction
	logic [7:0]  paddr;       // Byte address
	logic [31:0] pwdata;      // Write data
	logic [31:0] prdata;      // Read data
	logic        pready;      // Ready
	logic        pslverr;     // Error
	logic [31:0] r;           // Last read data
	logic        e;           // Last error flag
	int          fail_count;  // Mismatches
	int          total_checks; // Comparisons
	ihz_decode DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr));
	// ****************************************
	// Bus and compare tasks
	// ****************************************
	// One full transfer; holds the request until pready is seen high
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp) begin
			fail_count++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
		apb(1'b0, a, 32'h0);
		chk(r, exp);
		chk({31'h0, e}, 32'h0);
	endtask
	// ****************************************
	// Scenarios
	// ****************************************
	// Every register comes out of reset at its documented value
	task automatic t_reset;
		for (int a = 0; a <= 32; a += 4)
			rdc(a[7:0], (a == A_COPEN) ? {28'h0, COPEN_RST} : 32'h0);
	endtask
	// Signed add: plain sum, wrap to zero, and an overflow that keeps the result
	task automatic t_add;
		logic [31:0] w;
		w = {OP_SPECIAL, 5'h01, 5'h02, 5'h03, 5'h00, FN_ADD};
		apb(1'b1, A_OPA, 32'h0000_0005); apb(1'b1, A_OPB, 32'h0000_0007);
		apb(1'b1, A_INSTR, w);
		rdc(A_RES, 32'h0000_000C);
		rdc(A_DEC, {8'h00, 3'h0, 3'h0, 3'h0, 5'h01, 5'h02, 5'h03});
		rdc(A_STAT, 32'h0000_0008);
		apb(1'b1, A_OPA, 32'h7FFF_FFFF); apb(1'b1, A_OPB, 32'h0000_0001);
		apb(1'b1, A_INSTR, w);
		rdc(A_RES, 32'h0000_000C);
		rdc(A_STAT, 32'h0000_0009);
		apb(1'b1, A_STAT, 32'h0000_0001);
		rdc(A_STAT, 32'h0000_0008);
		apb(1'b1, A_OPA, 32'hFFFF_FFFF);
		apb(1'b1, A_INSTR, w);
		rdc(A_RES, 32'h0000_0000);
		rdc(A_STAT, 32'h0000_0008);
	endtask
	// First two rows of the main map decode to their groups with no fault
	task automatic t_map;
		logic [2:0] cls;
		for (int c = 0; c < 16; c++) begin
			cls = (c < 4) ? c[2:0] : ((c < 8) ? 3'h4 : 3'h5);
			apb(1'b1, A_INSTR, {c[5:0], 26'h0});
			rdc(A_DEC, {8'h00, cls, c[5:3], c[2:0], 15'h0});
			rdc(A_STAT, 32'h0000_0000);
		end
	endtask
	// Reserved and missing coprocessor opcodes; inhibit no-op raises nothing
	task automatic t_fault;
		apb(1'b1, A_INSTR, 32'h6000_0000);
		rdc(A_STAT, 32'h0000_0002);
		apb(1'b1, A_STAT, 32'h0000_0002);
		apb(1'b1, A_INSTR, 32'hFC00_0000);
		rdc(A_STAT, 32'h0000_0002);
		apb(1'b1, A_STAT, 32'h0000_0002);
		apb(1'b1, A_INSTR, {OP_COPZ, 2'h1, 26'h0});
		rdc(A_STAT, 32'h0000_0004);
		apb(1'b1, A_STAT, 32'h0000_0004);
		apb(1'b1, A_COPEN, 32'h0000_0003);
		apb(1'b1, A_INSTR, {OP_COPZ, 2'h1, 26'h0});
		apb(1'b1, A_INSTR, {OP_COPZ, 2'h0, 26'h0});
		apb(1'b1, A_INSTR, SUPERSCALAR_INHIBIT_NOOP_WORD);
		rdc(A_STAT, 32'h0000_0000);
		rdc(A_INSTR, SUPERSCALAR_INHIBIT_NOOP_WORD);
	endtask
	// Each hazard stays pending for exactly its spacing in instructions
	task automatic t_hazard;
		int sp;
		for (int k = 0; k < NEV; k++) begin
			sp = SPACING[k*3 +: 3];
			apb(1'b1, A_EVT, 32'h1 << k);
			rdc(A_PEND, 32'h1 << k);
			for (int i = 1; i < sp; i++) apb(1'b1, A_INSTR, SUPERSCALAR_INHIBIT_NOOP_WORD);
			rdc(A_PEND, 32'h1 << k);
			apb(1'b1, A_INSTR, SUPERSCALAR_INHIBIT_NOOP_WORD);
			rdc(A_PEND, 32'h0);
		end
	endtask
	// An unmapped write and a misaligned read answer with an error; the misaligned read returns zero
	task automatic t_unmapped;
		apb(1'b1, 8'h24, 32'hFFFF_FFFF);
		chk({31'h0, e}, 32'h1);
		apb(1'b0, 8'h02, 32'h0);
		chk({31'h0, e}, 32'h1);
		chk(r, 32'h0);
		rdc(A_EVT, 32'h0);
	endtask
	// ****************************************
	// Verdict, clock, watchdog and sequence
	// ****************************************
	task automatic final_report;
		if (fail_count == 0 && total_checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	initial begin
		pclk = 1'b0;
		forever #4 pclk = ~pclk;
	end
	// Generous bound: the whole sequence needs a few hundred cycles
	initial begin
		#(8 * 20000);
		fail_count++;
		final_report();
	end
	initial begin
		presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
		paddr = 8'h00; pwdata = 32'h0; fail_count = 0; total_checks = 0;
		repeat (10) @(posedge pclk);
		presetn <= 1'b1;
		t_reset();
		t_add();
		t_map();
		t_fault();
		t_hazard();
		t_unmapped();
		final_report();
	end
endmodule
`default_nettype wire
